// ---- core/lcd_instr_decoder.sv ----
// lcd_instr_decoder: clear, home, entry mode and display control commands
// assumes bus inputs synchronous to ref_clk; host waits for busy_flag low
//
// How it works
// - rs low, write, byte 01 decodes as clear-display.
// - clear-display writes space code 20 into every display memory cell.
// - clear-display loads address counter 00 and sets step direction increment.
// - clear-display keeps the shift-on-entry flag unchanged.
// - after clear, cursor and blink sit at line one, leftmost column.
// - byte with highest set bit 1 decodes as return-home.
// - return-home loads counter 00, cancels display shift, memory kept.
// - highest set bit 2: entry-mode set, bit1 direction, bit0 shift.
// - each data read or write steps counter up or down by one.
// - with shift-on-entry, display memory writes shift the whole display.
// - no entry shift on display reads or any glyph memory access.
// - highest set bit 3: display, cursor and blink enables from bits 2..0.
// - display off blanks panel, memory kept, content returns when on.
// - visible cursor drawn as five-dot row on cell row eight.
// - blink toggles cursor character with 600 ms period, cursor allowed too.
// - busy flag high while clear-display or return-home executes; host waits for it.
// - clear-display keeps busy for its 14.13 ms execution time.
// - return-home keeps busy for its 600 us execution time.
`timescale 1ns/1ps
module lcd_instr_decoder
  import lcd_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // host command strobe
  input wire logic cmd_strobe,
  input wire logic register_select,
  input wire logic read_not_write,
  input wire logic [7:0] data_in,
  // status
  output logic busy_flag,
  output logic [6:0] address_counter,
  output mode_flags_t flags,
  output logic [5:0] display_shift,
  // panel view
  output cursor_view_t view,
  // display data memory read port
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data
);

  function automatic logic is_cmd(input logic [7:0] d, input int unsigned b);
    is_cmd = (d >> b) == 8'h01;
  endfunction

  logic cmd_wr;
  logic data_acc;
  logic do_clear;
  logic do_home;
  logic do_entry;
  logic do_disp;
  logic glyph_sel;
  logic [23:0] busy_cnt;
  logic [23:0] blink_cnt;
  logic blink_phase;
  logic [7:0] dd_mem [DD_DEPTH];
  logic [6:0] next_ac;

  assign cmd_wr = cmd_strobe && !register_select && !read_not_write;
  assign data_acc = cmd_strobe && register_select;
  assign do_clear = cmd_wr && data_in == 8'h01;
  assign do_home = cmd_wr && is_cmd(data_in, 1);
  assign do_entry = cmd_wr && is_cmd(data_in, 2);
  assign do_disp = cmd_wr && is_cmd(data_in, 3);
  assign glyph_sel = address_counter >= GLYPH_BASE;
  assign busy_flag = busy_cnt != 24'h000000;

  // execution timer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt <= 24'h000000;
    end else if (do_clear) begin
      busy_cnt <= 24'(CLEAR_CYC);
    end else if (do_home) begin
      busy_cnt <= 24'(HOME_CYC);
    end else if (busy_flag) begin
      busy_cnt <= busy_cnt - 24'h000001;
    end
  end

  // mode flags
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= FLAGS_RESET;
    end else if (do_clear) begin
      flags.step_inc <= 1'b1;
    end else if (do_entry) begin
      flags.step_inc <= data_in[1];
      flags.shift_on_entry <= data_in[0];
    end else if (do_disp) begin
      flags.display_on <= data_in[2];
      flags.cursor_on <= data_in[1];
      flags.blink_on <= data_in[0];
    end
  end

  always_comb begin
    next_ac = flags.step_inc ? address_counter + 7'h01
                             : address_counter - 7'h01;
  end

  // address counter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      address_counter <= AC_HOME;
    end else if (do_clear || do_home) begin
      address_counter <= AC_HOME;
    end else if (data_acc) begin
      address_counter <= next_ac;
    end
  end

  // display shift
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      display_shift <= SHIFT_ZERO;
    end else if (do_clear || do_home) begin
      display_shift <= SHIFT_ZERO;
    end else if (data_acc && !read_not_write && !glyph_sel
                 && flags.shift_on_entry) begin
      if (flags.step_inc) begin
        display_shift <= (display_shift == SHIFT_LIMIT) ? SHIFT_ZERO
                         : display_shift + 6'h01;
      end else begin
        display_shift <= (display_shift == SHIFT_ZERO) ? SHIFT_LIMIT
                         : display_shift - 6'h01;
      end
    end
  end

  // display data memory: clear fills all cells, data writes store one
  genvar gi;
  generate
    for (gi = 0; gi < DD_DEPTH; gi++) begin : g_dd
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          dd_mem[gi] <= SPACE_CODE;
        end else if (do_clear) begin
          dd_mem[gi] <= SPACE_CODE;
        end else if (data_acc && !read_not_write
                     && address_counter == 7'(gi)) begin
          dd_mem[gi] <= data_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= (rd_addr < 6'(DD_DEPTH)) ? dd_mem[rd_addr] : 8'h00;
    end
  end

  // blink timebase
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt <= 24'h000000;
      blink_phase <= 1'b0;
    end else if (blink_cnt == 24'(BLINK_HALF_CYC - 1)) begin
      blink_cnt <= 24'h000000;
      blink_phase <= flags.blink_on && !blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 24'h000001;
      if (!flags.blink_on) begin
        blink_phase <= 1'b0;
      end
    end
  end

  // cursor position and overlay
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      view.col <= 6'h00;
      view.line <= 2'h0;
      view.cursor_row <= 1'b0;
      view.blink_dark <= 1'b0;
      view.visible <= 1'b0;
    end else begin
      view.blink_dark <= blink_phase;
      view.col <= {2'h0, address_counter[3:0]};
      view.line <= address_counter[5:4];
      view.cursor_row <= flags.cursor_on && flags.display_on;
      view.visible <= flags.display_on;
    end
  end

  AST_CLEAR_BUSY: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_clear |=> busy_flag [*8]) else $error("clear busy too short");
  AST_HOME_BUSY: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_home |=> busy_flag [*8]) else $error("home busy too short");
  AST_CLEAR_AC: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_clear |=> address_counter == AC_HOME && flags.step_inc)
    else $error("clear did not home");
  AST_CLEAR_S: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_clear |=> flags.shift_on_entry == $past(flags.shift_on_entry))
    else $error("clear changed shift flag");
  AST_HOME_SHIFT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_home |=> display_shift == SHIFT_ZERO && address_counter == AC_HOME)
    else $error("home did not reset");
  AST_ENTRY: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_entry |=> flags.step_inc == $past(data_in[1])
      && flags.shift_on_entry == $past(data_in[0]))
    else $error("entry mode not stored");
  AST_STEP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    data_acc && flags.step_inc |=> address_counter
      == 7'($past(address_counter) + 7'h01))
    else $error("counter did not step up");
  AST_NO_READ_SHIFT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    data_acc && read_not_write |=> $stable(display_shift))
    else $error("read shifted display");
  AST_DISP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_disp |=> flags.display_on == $past(data_in[2])
      ##1 view.visible == flags.display_on)
    else $error("display control not applied");
  AST_CLEAR_MEM: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_clear |=> dd_mem[0] == SPACE_CODE && dd_mem[47] == SPACE_CODE)
    else $error("memory not cleared");

endmodule // lcd_instr_decoder

// ---- core/lcd_ctrl_pkg.sv ----
// lcd_ctrl_pkg: constants and carrier types for the instruction decoder
// assumes a 25 MHz reference clock standing in for the oscillator timebase
package lcd_ctrl_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int CLEAR_US = 14130;
  localparam int HOME_US = 600;
  localparam int BLINK_MS = 600;
  localparam int CLEAR_CYC = CLEAR_US * (CLK_HZ / 1000000);
  localparam int HOME_CYC = HOME_US * (CLK_HZ / 1000000);
  localparam int BLINK_HALF_CYC = BLINK_MS * (CLK_HZ / 1000) / 2;
  localparam int DD_DEPTH = 48;
  localparam logic [6:0] AC_HOME = 7'h00;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] GLYPH_BASE = 7'h40;
  localparam logic [5:0] SHIFT_ZERO = 6'h00;
  localparam logic [5:0] SHIFT_LIMIT = 6'h0f;

  typedef struct packed {
    logic step_inc;
    logic shift_on_entry;
    logic display_on;
    logic cursor_on;
    logic blink_on;
  } mode_flags_t;

  localparam mode_flags_t FLAGS_RESET = 5'h10;

  typedef struct packed {
    logic [5:0] col;
    logic [1:0] line;
    logic cursor_row;
    logic blink_dark;
    logic visible;
  } cursor_view_t;
endpackage

// ---- testbench/host_model.sv ----
// host_model: processor side that issues bus accesses to the decoder
// assumes issue() is called just after a rising edge of ref_clk
`timescale 1ns/1ps
module host_model (
  // bus
  input wire logic ref_clk,
  input wire logic busy_flag,
  output logic cmd_strobe,
  output logic register_select,
  output logic read_not_write,
  output logic [7:0] data_in
);
  initial begin
    cmd_strobe = 1'b0;
    register_select = 1'b0;
    read_not_write = 1'b0;
    data_in = 8'hff;
  end
  // acc is {select, read, byte}; hold waits for busy low first, for at most 20000 edges
  task automatic issue(input logic [9:0] acc, input bit hold);
    int n;
    n = 0;
    while (hold && busy_flag !== 1'b0 && n < 20000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    {register_select, read_not_write, data_in} = acc;
    cmd_strobe = 1'b1;
    @(posedge ref_clk);
    #1 cmd_strobe = 1'b0;
    data_in = ~acc[7:0];
    // one idle edge so a following call never re-raises the strobe at once
    @(posedge ref_clk);
    #1;
  endtask
endmodule // host_model

// ---- testbench/tb_top.sv ----
// tb_top: mode command table, then memory, home, clear and reset cases
// assumes package counts; the clear busy span is cut short by reset
`timescale 1ns/1ps
module tb_top;
  import lcd_ctrl_pkg::*;
  logic ref_clk, rst_b, cmd_strobe, register_select, read_not_write;
  logic busy_flag;
  logic [7:0] data_in, rd_data;
  logic [6:0] address_counter;
  logic [5:0] display_shift, rd_addr, sh;
  mode_flags_t flags;
  cursor_view_t view;
  int fail_count, cmp_count, n;
  // command byte beside the expected flags
  logic [12:0] rows [13] = '{{8'h04, 5'h00}, {8'h07, 5'h18},
    {8'h0f, 5'h1f}, {8'h0a, 5'h1a}, {8'h0d, 5'h1d}, {8'h09, 5'h19},
    {8'h0b, 5'h1b}, {8'h0e, 5'h1e}, {8'h0c, 5'h1c}, {8'h08, 5'h18},
    {8'h00, 5'h18}, {8'h06, 5'h10}, {8'h05, 5'h08}};
  host_model host_model_inst (.ref_clk(ref_clk), .busy_flag(busy_flag),
    .cmd_strobe(cmd_strobe), .register_select(register_select),
    .read_not_write(read_not_write), .data_in(data_in));
  lcd_instr_decoder lcd_instr_decoder_inst (.ref_clk(ref_clk),
    .rst_b(rst_b), .cmd_strobe(cmd_strobe),
    .register_select(register_select), .read_not_write(read_not_write),
    .data_in(data_in), .busy_flag(busy_flag),
    .address_counter(address_counter), .flags(flags),
    .display_shift(display_shift), .view(view), .rd_addr(rd_addr),
    .rd_data(rd_data));
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("Error %0t %s", $time, m);
    end
  endtask
  task step;
    @(posedge ref_clk);
    #1;
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #(40 * 40000);
    fail_count++;
    $display("Error %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    rst_b = 1'b0;
    rd_addr = 6'h00;
    repeat (16) step();
    rst_b = 1'b1;
    foreach (rows[i]) begin
      host_model_inst.issue({2'b00, rows[i][12:5]}, 1'b1);
      step();
      chk(flags === rows[i][4:0], "mode flags");
    end
    $display("mode table done");
    sh = display_shift;
    host_model_inst.issue({2'b10, 8'h41}, 1'b1);
    step();
    chk(address_counter === 7'h7f, "decrement");
    chk(display_shift !== sh, "entry shift");
    chk(rd_data === 8'h41 && view.visible === 1'b0, "kept while off");
    sh = display_shift;
    host_model_inst.issue({2'b10, 8'h42}, 1'b1);
    step();
    chk(display_shift === sh && address_counter === 7'h7e, "glyph");
    host_model_inst.issue(10'h002, 1'b1);
    n = 0;
    while (busy_flag === 1'b1 && n < 20000) begin
      step();
      n++;
    end
    chk(n >= HOME_CYC - 2 && n <= HOME_CYC + 2, "home busy");
    chk(address_counter === AC_HOME && display_shift === 0, "home");
    host_model_inst.issue(10'h007, 1'b1);
    host_model_inst.issue({2'b10, 8'h43}, 1'b1);
    sh = display_shift;
    chk(sh === 6'h01, "increment shift");
    host_model_inst.issue({2'b11, 8'h00}, 1'b1);
    step();
    chk(address_counter === 7'h02 && display_shift === sh, "read");
    $display("memory and home done");
    host_model_inst.issue(10'h005, 1'b1);
    host_model_inst.issue(10'h00f, 1'b1);
    host_model_inst.issue(10'h001, 1'b1);
    step();
    step();
    chk(busy_flag === 1'b1 && address_counter === AC_HOME, "clear");
    chk(flags.step_inc === 1'b1, "clear direction");
    chk(flags.shift_on_entry === 1'b1, "clear keeps shift");
    chk(rd_data === SPACE_CODE, "clear fill");
    chk(view.col === 6'h00 && view.line === 2'h0, "clear cursor");
    chk(view.cursor_row === 1'b1 && view.visible === 1'b1, "cursor");
    chk(view.blink_dark === 1'b0, "blink first half bright");
    repeat (100) step();
    chk(busy_flag === 1'b1, "clear busy");
    rst_b = 1'b0;
    step();
    chk(busy_flag === 1'b0 && flags === FLAGS_RESET, "reset");
    rst_b = 1'b1;
    host_model_inst.issue(10'h00c, 1'b1);
    step();
    chk(flags === 5'h14 && busy_flag === 1'b0, "after reset");
    $display("clear and reset done");
    summarize();
  end
endmodule // tb_top
